// file: bench/imbt_assertions.sv
// Purpose: timing checks on the serial clock and data enables
// Assumes: commands arrive within a quarter period, so phases are exact
// Notes: bound in tb
`timescale 1ns/1ps
`default_nettype none
module imbt_assertions (
  input wire logic clock,
  input wire logic srst,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic [11:0] scl_run_reg; // samples since scl_oe last changed
  logic [11:0] sda_run_reg; // samples since sda_oe last changed
  logic start_reg; // start seen in this clock-high phase
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // run counters saturate so a long idle cannot wrap
  always_ff @(posedge clock) begin
    scl_run_reg <= (srst || $changed(scl_oe)) ? 12'h001 : scl_run_reg + 12'(~&scl_run_reg);
    sda_run_reg <= (srst || $changed(sda_oe)) ? 12'h001 : sda_run_reg + 12'(~&sda_run_reg);
    start_reg <= !srst && !scl_oe && (start_reg || $rose(sda_oe));
  end
  sequence s_start;
    !scl_oe && $rose(sda_oe);
  endsequence
  a_start_setup: assert property (s_start |-> scl_run_reg >= 12'h400)
    else $error("start setup too short");
  a_bus_free: assert property (s_start |-> sda_run_reg >= 12'h200)
    else $error("bus free gap too short");
  a_start_hold: assert property ($rose(scl_oe) && start_reg |-> sda_run_reg == 12'h200)
    else $error("start hold wrong");
  a_stop_setup: assert property (!scl_oe && $fell(sda_oe) |-> scl_run_reg == 12'h200)
    else $error("stop setup wrong");
  a_clock_high: assert property ($rose(scl_oe) && !start_reg |-> scl_run_reg == 12'h200)
    else $error("clock high phase wrong");
  a_clock_low: assert property ($fell(scl_oe) |-> scl_run_reg == 12'h200)
    else $error("clock low phase wrong");
  a_data_edge: assert property ($changed(sda_oe) && scl_oe |-> scl_run_reg == 12'h100)
    else $error("data changed off its point");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
endmodule
`default_nettype wire

// file: bench/imbt_slave_model.sv
// Purpose: serial slave that captures written bits and serves read bits
// Assumes: released data line floats high through the pull-up
// Notes: talk selects whether it drives read bits
`timescale 1ns/1ps
`default_nettype none
module imbt_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic talk,
  input wire logic [7:0] tx_byte,
  output logic sda_pull,
  output logic [7:0] rx_byte
);
  int idx; // next read bit, msb first
  initial begin
    sda_pull = 1'b0;
    rx_byte = 8'h00;
    idx = 0;
  end
  always @(posedge scl) rx_byte = {rx_byte[6:0], sda};
  always @(negedge sda) if (scl) idx = 0;
  // new bit a little after the clock falls, well before the master samples
  always @(negedge scl) begin
    #100 sda_pull = talk && !tx_byte[3'h7 - idx[2:0]];
    if (talk) idx++;
  end
endmodule
`default_nettype wire

// file: bench/tb.sv
// Purpose: self-checking bench for the serial master bit timing
// Assumes: phase timing is judged by the bound checker
// Notes: inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, srst, cmd_valid, talk, cmd_ready, bus_busy;
  logic scl_out, scl_oe, sda_out, sda_oe, sda_pull, scl, sda;
  logic [7:0] rx_byte, tx_byte;
  imbt_pkg::imbt_cmd_t cmd;
  imbt_pkg::imbt_resp_t resp;
  int n_mismatch, checks_done;
  assign scl = ~scl_oe;
  assign sda = ~(sda_oe | sda_pull);
  imbt_master u_imbt_master (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .resp(resp), .bus_busy(bus_busy), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  imbt_slave_model u_imbt_slave_model (.scl(scl), .sda(sda), .talk(talk), .tx_byte(tx_byte),
    .sda_pull(sda_pull), .rx_byte(rx_byte));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bit slot; waits for its done pulse under a bound
  task automatic op(input imbt_pkg::imbt_cmd_kind_t k, input logic d);
    int n;
    @(negedge clock);
    cmp({7'h00, cmd_ready}, 8'h01);
    cmd_valid = 1'b1;
    cmd.kind = k;
    cmd.data = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    while (resp.done !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    cmp({7'h00, resp.done}, 8'h01);
    cmp({7'h00, bus_busy}, 8'h01);
  endtask
  task automatic t_write();
    op(imbt_pkg::IMBT_CMD_START, 1'b0);
    op(imbt_pkg::IMBT_CMD_WRITE, 1'b1);
    op(imbt_pkg::IMBT_CMD_WRITE, 1'b0);
    op(imbt_pkg::IMBT_CMD_WRITE, 1'b1);
    op(imbt_pkg::IMBT_CMD_WRITE, 1'b1);
    cmp(rx_byte & 8'h0F, 8'h0B);
    op(imbt_pkg::IMBT_CMD_STOP, 1'b0);
    $display("write test done");
  endtask
  task automatic t_read();
    op(imbt_pkg::IMBT_CMD_START, 1'b0);
    op(imbt_pkg::IMBT_CMD_WRITE, 1'b1);
    talk = 1'b1;
    for (int i = 0; i < 3; i++) begin
      op(imbt_pkg::IMBT_CMD_READ, 1'b1);
      cmp({7'h00, resp.rx_bit}, {7'h00, tx_byte[7 - i]});
    end
    talk = 1'b0;
    op(imbt_pkg::IMBT_CMD_WRITE, 1'b0);
    op(imbt_pkg::IMBT_CMD_START, 1'b0);
    op(imbt_pkg::IMBT_CMD_STOP, 1'b0);
    @(negedge clock);
    cmp({7'h00, bus_busy}, 8'h00);
    $display("read test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #800000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    talk = 1'b0;
    tx_byte = 8'hA0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    t_write();
    t_read();
    tally_and_finish();
  end
endmodule
bind imbt_master imbt_assertions u_imbt_assertions (.clock(clock), .srst(srst),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// file: design/imbt_defines.svh
// Purpose: timing constants for the two-wire master bit timing block
// Assumes: every count is in cycles of proc_bus_clock
// Notes: definitions only
`ifndef IMBT_DEFINES_SVH
`define IMBT_DEFINES_SVH
`define IMBT_CNT_W 11
`define IMBT_HALF_PERIOD 11'h200
`define IMBT_FULL_PERIOD 11'h400
`define IMBT_QUARTER 11'h100
`define IMBT_STOP_SETUP 11'h200
`define IMBT_BUS_FREE 11'h200
`define IMBT_START_SETUP 11'h400
`define IMBT_START_HOLD 11'h200
`define IMBT_SYNC_LAG 11'h002
`define IMBT_CNT_ONE 11'h001
`define IMBT_CNT_ZERO 11'h000
`endif

// file: design/imbt_master.sv
// Purpose: bit-level timing for a two-wire serial master port
// Assumes: clock is proc_bus_clock; srst synchronous active high
// Notes: lines are open drain; enable high pulls the line low
`timescale 1ns/1ps
`default_nettype none
`include "imbt_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - each serial clock period is 1024 cycles
// - serial clock high 512, low 512
// - stop: clock high 512 before data release
// - bus idle 512 cycles after stop
// - clock high 1024 before start data fall
// - start: data low 512 before clock low
// - new data value 256 after clock fall
// - old data held 256 after clock fall
// - read sample 256 into clock high
module imbt_master (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire imbt_pkg::imbt_cmd_t cmd,
  output logic cmd_ready,
  output imbt_pkg::imbt_resp_t resp,
  output logic bus_busy,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // phase states of a bit slot
  typedef enum logic [3:0] {
    IMBT_IDLE,
    IMBT_ST_SETUP,
    IMBT_ST_HOLD,
    IMBT_BIT_LOW_A,
    IMBT_BIT_LOW_B,
    IMBT_BIT_HIGH,
    IMBT_SP_LOW_A,
    IMBT_SP_LOW_B,
    IMBT_SP_SETUP,
    IMBT_FREE
  } imbt_state_t;

  imbt_state_t state_reg; // current phase
  logic [`IMBT_CNT_W-1:0] cnt_reg; // cycles left in phase
  imbt_pkg::imbt_cmd_t cur_reg; // command in progress
  logic scl_low_reg; // pull clock low
  logic sda_low_reg; // pull data low
  logic rx_reg; // captured bit
  logic [1:0] sda_sync_reg; // data line synchroniser
  logic [1:0] scl_sync_reg; // clock line synchroniser, observed only
  logic last_cnt; // final cycle of phase

  assign last_cnt = (cnt_reg == `IMBT_CNT_ONE);

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers: pins come from outside the clock domain
  always_ff @(posedge clock) begin
    if (srst) begin
      sda_sync_reg <= 2'h3;
      scl_sync_reg <= 2'h3;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // phase sequencer; all counts step on clock alone, no stretching
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= IMBT_IDLE;
      cnt_reg <= `IMBT_CNT_ZERO;
      cur_reg <= '0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else begin
      if (cnt_reg != `IMBT_CNT_ZERO) begin
        cnt_reg <= cnt_reg - `IMBT_CNT_ONE;
      end
      case (state_reg)
        IMBT_IDLE: begin
          if (cmd_valid) begin
            cur_reg <= cmd;
            // the low-phase count has run since the clock fell; a command that
            // comes after it ran out restarts it, which stretches the low phase
            if (cnt_reg == `IMBT_CNT_ZERO || last_cnt) begin
              cnt_reg <= `IMBT_QUARTER;
            end
            if (cmd.kind == imbt_pkg::IMBT_CMD_START && !scl_low_reg) begin
              // clock already high: straight into the start setup time
              state_reg <= IMBT_ST_SETUP;
              cnt_reg <= `IMBT_START_SETUP;
            end else if (cmd.kind == imbt_pkg::IMBT_CMD_STOP) begin
              state_reg <= IMBT_SP_LOW_A;
            end else begin
              // bits, and a repeated start that must first finish the low phase
              state_reg <= IMBT_BIT_LOW_A;
            end
          end
        end
        IMBT_ST_SETUP: begin
          // repeated start: data released during the low half first
          sda_low_reg <= 1'b0;
          if (last_cnt) begin
            sda_low_reg <= 1'b1;
            state_reg <= IMBT_ST_HOLD;
            cnt_reg <= `IMBT_START_HOLD;
          end
        end
        IMBT_ST_HOLD: begin
          if (last_cnt) begin
            scl_low_reg <= 1'b1;
            state_reg <= IMBT_IDLE;
            // low-phase count starts at the fall, not at the next command
            cnt_reg <= `IMBT_QUARTER;
          end
        end
        IMBT_BIT_LOW_A: begin
          // keep old data for a quarter period after the fall
          scl_low_reg <= 1'b1;
          if (last_cnt) begin
            // reads and a repeated start release data so the slave can drive it
            sda_low_reg <= (cur_reg.kind == imbt_pkg::IMBT_CMD_WRITE) ?
                           ~cur_reg.data : 1'b0;
            state_reg <= IMBT_BIT_LOW_B;
            cnt_reg <= `IMBT_QUARTER;
          end
        end
        IMBT_BIT_LOW_B: begin
          if (last_cnt) begin
            scl_low_reg <= 1'b0;
            if (cur_reg.kind == imbt_pkg::IMBT_CMD_START) begin
              // repeated start: data already released, now the setup time
              state_reg <= IMBT_ST_SETUP;
              cnt_reg <= `IMBT_START_SETUP;
            end else begin
              state_reg <= IMBT_BIT_HIGH;
              cnt_reg <= `IMBT_HALF_PERIOD;
            end
          end
        end
        IMBT_BIT_HIGH: begin
          if (last_cnt) begin
            scl_low_reg <= 1'b1;
            state_reg <= IMBT_IDLE;
            // keeps the period exact when the next command comes promptly
            cnt_reg <= `IMBT_QUARTER;
          end
        end
        IMBT_SP_LOW_A: begin
          scl_low_reg <= 1'b1;
          if (last_cnt) begin
            sda_low_reg <= 1'b1;
            state_reg <= IMBT_SP_LOW_B;
            cnt_reg <= `IMBT_QUARTER;
          end
        end
        IMBT_SP_LOW_B: begin
          if (last_cnt) begin
            scl_low_reg <= 1'b0;
            state_reg <= IMBT_SP_SETUP;
            cnt_reg <= `IMBT_STOP_SETUP;
          end
        end
        IMBT_SP_SETUP: begin
          if (last_cnt) begin
            sda_low_reg <= 1'b0;
            state_reg <= IMBT_FREE;
            cnt_reg <= `IMBT_BUS_FREE;
          end
        end
        IMBT_FREE: begin
          // no new command until the free gap has run out
          if (last_cnt) begin
            state_reg <= IMBT_IDLE;
          end
        end
        default: begin
          state_reg <= IMBT_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read sample a quarter period into the high phase at the pin; the two
  // synchroniser flops delay what we see, so the count is moved to match
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_reg <= 1'b0;
    end else if (state_reg == IMBT_BIT_HIGH &&
                 cnt_reg == (`IMBT_QUARTER - `IMBT_SYNC_LAG)) begin
      rx_reg <= sda_sync_reg[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs; drive only low, never high (open drain)
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      cmd_ready <= 1'b0;
      resp <= '0;
      bus_busy <= 1'b0;
    end else begin
      scl_oe <= scl_low_reg;
      sda_oe <= sda_low_reg;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      cmd_ready <= (state_reg == IMBT_IDLE) && !cmd_valid;
      resp.done <= last_cnt && (state_reg == IMBT_ST_HOLD ||
                   state_reg == IMBT_BIT_HIGH || state_reg == IMBT_FREE);
      resp.rx_bit <= rx_reg;
      bus_busy <= (state_reg != IMBT_IDLE) || scl_low_reg || sda_low_reg;
    end
  end

endmodule
`default_nettype wire

// file: design/imbt_pkg.sv
// Purpose: types for the two-wire master bit timing block
// Assumes: nothing
// Notes: holds types only; numbers live in the defines header
package imbt_pkg;
  // bit-level command kinds
  typedef enum logic [2:0] {
    IMBT_CMD_START,
    IMBT_CMD_WRITE,
    IMBT_CMD_READ,
    IMBT_CMD_STOP
  } imbt_cmd_kind_t;

  // one command with its data bit
  typedef struct packed {
    imbt_cmd_kind_t kind;
    logic data;
  } imbt_cmd_t;

  // result of a bit slot
  typedef struct packed {
    logic done;
    logic rx_bit;
  } imbt_resp_t;
endpackage
